/* File: core/sas_adc_top.sv */
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - the engine turns the held input into an unsigned 8-bit code.
// - software picks the supply or the pin as conversion reference.
// - conversions keep running in sleep when the rc clock is chosen.
// - clock select 00/01/10/11 gives osc/2, osc/8, osc/32, rc clock.
// - channel select 00..11 routes input 0..3 to the sample-and-hold.
// - writing go with the power bit set in the same write starts, go reads one while busy, hardware clears it.
// - power bit enables the converter; clear shuts it down.
// - on completion result loads, go clears and done sets together.
// - done flag sets whatever the irq enables say.
// - pins reset analog and read as zero on the digital port.
// - pin configuration writes may set port-change and external flags.
// - a done flag in sleep wakes the core only with the irq enable set and on the rc clock.
module sas_adc_top
  import sas_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [sas_pkg::SAS_ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [sas_pkg::SAS_ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_sleep,
  input wire logic i_rc_clk,
  input wire logic i_cmp,
  input wire logic [sas_pkg::SAS_PIN_N-1:0] i_port_pins,
  output logic [1:0] o_channel,
  output logic o_vref_pin,
  output logic o_hold,
  output logic o_power,
  output logic [sas_pkg::SAS_RES_W-1:0] o_dac_code,
  output logic o_wake
);
  import sas_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic aw_have_r;
  logic w_have_r;
  logic [SAS_ADDR_W-1:0] aw_addr_r;
  logic [7:0] w_data_r;
  logic w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic [1:0] clk_sel_r;
  logic [1:0] chan_r;
  logic go_r;
  logic power_r;
  logic [4:0] pcfg_r;
  logic [SAS_RES_W-1:0] result_r;
  logic done_flag_r;
  logic irq_en_r;
  logic gie_r;
  logic pchg_r;
  logic ext_r;
  logic [SAS_PIN_N-1:0] port_prev_r;
  logic wake_r;
  logic tick;

  sas_conv_if conv ();

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic do_write;
  logic wr_en;
  logic [5:0] w_idx;
  logic [5:0] r_idx;
  logic w_hit;
  logic r_hit;
  logic wr_ctrl;
  logic wr_pcfg;
  logic wr_flags;
  logic [7:0] ctrl_view;
  logic [7:0] flags_view;
  logic [SAS_PIN_N-1:0] port_view;
  logic [7:0] rd_mux;
  logic start;
  logic pchg_set;
  logic ext_set;

  // address and data are taken in either order, answer after both
  assign o_awready = !aw_have_r;
  assign o_wready = !w_have_r;
  assign do_write = aw_have_r && w_have_r && !bvalid_r;
  assign wr_en = do_write && w_strb_r;
  assign w_idx = aw_addr_r[7:2];
  assign r_idx = i_araddr[7:2];
  assign w_hit = (w_idx == SAS_IDX_CTRL[5:0]) ||
                 (w_idx == SAS_IDX_RESULT[5:0]) ||
                 (w_idx == SAS_IDX_PINCFG[5:0]) ||
                 (w_idx == SAS_IDX_FLAGS[5:0]) ||
                 (w_idx == SAS_IDX_PORT[5:0]);
  assign r_hit = (r_idx == SAS_IDX_CTRL[5:0]) ||
                 (r_idx == SAS_IDX_RESULT[5:0]) ||
                 (r_idx == SAS_IDX_PINCFG[5:0]) ||
                 (r_idx == SAS_IDX_FLAGS[5:0]) ||
                 (r_idx == SAS_IDX_PORT[5:0]);
  assign wr_ctrl = wr_en && (w_idx == SAS_IDX_CTRL[5:0]);
  assign wr_pcfg = wr_en && (w_idx == SAS_IDX_PINCFG[5:0]);
  assign wr_flags = wr_en && (w_idx == SAS_IDX_FLAGS[5:0]);
  assign o_arready = !rvalid_r;
  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;
  assign o_rvalid = rvalid_r;
  assign o_rresp = rresp_r;
  assign o_rdata = rdata_r;

  // ----------------------------------------------------------------
  // read views
  // ----------------------------------------------------------------
  // reserved control bits 5 and 1 read as zero
  assign ctrl_view = {clk_sel_r, 1'b0, chan_r, go_r, 1'b0, power_r};
  assign flags_view = {3'h0, ext_r, pchg_r, gie_r, irq_en_r,
                       done_flag_r};
  // analog pins read zero on the digital port
  assign port_view = i_port_pins & pcfg_r[SAS_PIN_N-1:0];
  assign rd_mux =
    (r_idx == SAS_IDX_CTRL[5:0]) ? ctrl_view :
    (r_idx == SAS_IDX_RESULT[5:0]) ? result_r :
    (r_idx == SAS_IDX_PINCFG[5:0]) ? {3'h0, pcfg_r} :
    (r_idx == SAS_IDX_FLAGS[5:0]) ? flags_view :
    (r_idx == SAS_IDX_PORT[5:0]) ? {4'h0, port_view} : 8'h00;

  // ----------------------------------------------------------------
  // conversion control
  // ----------------------------------------------------------------
  // start needs the power bit set in the same write, and an idle engine
  assign start = wr_ctrl && w_data_r[SAS_CTRL_GO_BIT]
                 && w_data_r[SAS_CTRL_PWR_BIT] && !go_r;
  // a pin view change after a configuration write raises these too
  assign pchg_set = (port_view != port_prev_r);
  assign ext_set = port_view[SAS_EXT_PIN]
                   && !port_prev_r[SAS_EXT_PIN];
  assign conv.start = start;
  assign conv.abort = !power_r;
  assign conv.tick = tick;
  assign conv.cmp = i_cmp;
  assign o_channel = chan_r;
  assign o_vref_pin = pcfg_r[SAS_PCFG_VREF_BIT];
  assign o_hold = conv.busy;
  assign o_power = power_r;
  assign o_dac_code = conv.dac_code;
  assign o_wake = wake_r;

  sas_tad_gen u_tad (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_run(conv.busy),
    .i_sleep(i_sleep),
    .i_rc_clk(i_rc_clk),
    .i_sel(clk_sel_r),
    .o_tick(tick)
  );

  sas_sar_core u_sar (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .conv(conv)
  );

  // bus channel bookkeeping
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= 8'h00;
      w_strb_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= SAS_RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= SAS_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      if (i_awvalid && !aw_have_r)
      begin
        aw_have_r <= 1'b1;
        aw_addr_r <= i_awaddr;
      end
      if (i_wvalid && !w_have_r)
      begin
        w_have_r <= 1'b1;
        w_data_r <= i_wdata[7:0];
        w_strb_r <= i_wstrb[0];
      end
      if (do_write)
      begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= w_hit ? SAS_RESP_OKAY : SAS_RESP_SLVERR;
      end
      else if (bvalid_r && i_bready)
        bvalid_r <= 1'b0;
      if (i_arvalid && !rvalid_r)
      begin
        rvalid_r <= 1'b1;
        rdata_r <= {24'h00_0000, rd_mux};
        rresp_r <= r_hit ? SAS_RESP_OKAY : SAS_RESP_SLVERR;
      end
      else if (rvalid_r && i_rready)
        rvalid_r <= 1'b0;
    end
  end

  // control fields freeze while a conversion runs; power may still drop
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      clk_sel_r <= SAS_CTRL_RST[7:6];
      chan_r <= SAS_CTRL_RST[4:3];
      go_r <= 1'b0;
      power_r <= 1'b0;
    end
    else
    begin
      if (wr_ctrl && !go_r)
      begin
        clk_sel_r <= w_data_r[SAS_CTRL_CLK_LSB +: 2];
        chan_r <= w_data_r[SAS_CTRL_CHAN_LSB +: 2];
      end
      if (wr_ctrl)
        power_r <= w_data_r[SAS_CTRL_PWR_BIT];
      if (start)
        go_r <= 1'b1;
      else if (conv.done || !power_r)
        go_r <= 1'b0;
    end
  end

  // result, pin configuration and flags; hardware set wins over clear
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      result_r <= 8'h00;
      pcfg_r <= SAS_PCFG_RST;
      done_flag_r <= 1'b0;
      irq_en_r <= 1'b0;
      gie_r <= 1'b0;
      pchg_r <= 1'b0;
      ext_r <= 1'b0;
      port_prev_r <= '0;
      wake_r <= 1'b0;
    end
    else
    begin
      port_prev_r <= port_view;
      if (conv.done)
        result_r <= conv.result;
      if (wr_pcfg)
        pcfg_r <= w_data_r[4:0];
      if (wr_flags)
      begin
        irq_en_r <= w_data_r[SAS_FLG_IRQEN];
        gie_r <= w_data_r[SAS_FLG_GIE];
      end
      done_flag_r <= conv.done ||
        (wr_flags ? w_data_r[SAS_FLG_DONE] : done_flag_r);
      pchg_r <= pchg_set ||
        (wr_flags ? w_data_r[SAS_FLG_PCHG] : pchg_r);
      ext_r <= ext_set || (wr_flags ? w_data_r[SAS_FLG_EXT] : ext_r);
      // other clocks stop in sleep, so only the rc clock can wake
      wake_r <= done_flag_r && irq_en_r && i_sleep
                && (clk_sel_r == SAS_CLK_RC);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  start_needs_power_a: assert property (
    $rose(go_r) |-> power_r)
    else $error("go set without power");
  done_loads_all_a: assert property (
    conv.done |=> (!go_r && done_flag_r && result_r == $past(conv.result)))
    else $error("completion did not update go, flag and result");
  flag_ignores_enable_a: assert property (
    (conv.done && !irq_en_r && !gie_r) |=> done_flag_r)
    else $error("done flag gated by enables");
  go_tracks_busy_a: assert property (
    go_r == (conv.busy || conv.done))
    else $error("go flag differs from engine activity");
  div8_spacing_a: assert property (
    (tick && clk_sel_r == SAS_CLK_DIV8 && !i_sleep && conv.busy)
      |=> (!tick)[*7])
    else $error("osc/8 tick spacing wrong");
  power_off_stops_a: assert property (
    (!power_r && !start) |=> (!go_r && !conv.busy))
    else $error("conversion kept running with power off");
  chan_stable_run_a: assert property (
    (go_r && $past(go_r)) |-> ($stable(o_channel) && $stable(result_r)))
    else $error("channel or result changed mid conversion");
  port_analog_zero_a: assert property (
    rvalid_r && $past(i_arvalid && !rvalid_r)
      && $past(r_idx) == SAS_IDX_PORT[5:0]
      |-> (rdata_r[3:0] & ~$past(pcfg_r[3:0])) == 4'h0)
    else $error("analog pin read non-zero");
  wake_rc_only_a: assert property (
    o_wake |-> ($past(i_sleep) && $past(clk_sel_r) == SAS_CLK_RC))
    else $error("wake without rc clock in sleep");
  sleep_osc_hold_a: assert property (
    (i_sleep && clk_sel_r != SAS_CLK_RC) |-> !tick)
    else $error("oscillator tick during sleep");
endmodule : sas_adc_top

/* File: core/sas_conv_if.sv */
`timescale 1ns/1ps
// control side to successive-approximation engine
interface sas_conv_if;
  import sas_pkg::*;
  logic start;
  logic abort;
  logic tick;
  logic cmp;
  logic busy;
  logic done;
  logic [SAS_RES_W-1:0] result;
  logic [SAS_RES_W-1:0] dac_code;
  modport ctrl (output start, output abort, output tick, output cmp,
    input busy, input done, input result, input dac_code);
  modport eng (input start, input abort, input tick, input cmp,
    output busy, output done, output result, output dac_code);
endinterface : sas_conv_if

/* File: core/sas_pkg.sv */
package sas_pkg;
  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam int SAS_ADDR_W = 8;
  localparam logic [7:0] SAS_IDX_CTRL = 8'h1F;
  localparam logic [7:0] SAS_IDX_RESULT = 8'h1E;
  localparam logic [7:0] SAS_IDX_PINCFG = 8'h20;
  localparam logic [7:0] SAS_IDX_FLAGS = 8'h21;
  localparam logic [7:0] SAS_IDX_PORT = 8'h22;
  // ----------------------------------------------------------------
  // converter_control_reg fields
  // ----------------------------------------------------------------
  localparam int SAS_CTRL_CLK_LSB = 6;
  localparam int SAS_CTRL_CHAN_LSB = 3;
  localparam int SAS_CTRL_GO_BIT = 2;
  localparam int SAS_CTRL_PWR_BIT = 0;
  localparam logic [7:0] SAS_CTRL_RST = 8'h00;
  // pin_analog_config: bits 3:0 one per pin, 1 = digital; bit 4 = vref pin
  localparam int SAS_PIN_N = 4;
  localparam int SAS_PCFG_VREF_BIT = 4;
  localparam logic [4:0] SAS_PCFG_RST = 5'h00;
  // flags register bits
  localparam int SAS_FLG_DONE = 0;
  localparam int SAS_FLG_IRQEN = 1;
  localparam int SAS_FLG_GIE = 2;
  localparam int SAS_FLG_PCHG = 3;
  localparam int SAS_FLG_EXT = 4;
  localparam int SAS_EXT_PIN = 2;
  // ----------------------------------------------------------------
  // conversion clock select codes and divider limits
  // ----------------------------------------------------------------
  localparam logic [1:0] SAS_CLK_DIV2 = 2'h0;
  localparam logic [1:0] SAS_CLK_DIV8 = 2'h1;
  localparam logic [1:0] SAS_CLK_DIV32 = 2'h2;
  localparam logic [1:0] SAS_CLK_RC = 2'h3;
  localparam logic [4:0] SAS_LIM_DIV2 = 5'h01;
  localparam logic [4:0] SAS_LIM_DIV8 = 5'h07;
  localparam logic [4:0] SAS_LIM_DIV32 = 5'h1F;
  localparam int SAS_RES_W = 8;
  localparam logic [1:0] SAS_RESP_OKAY = 2'h0;
  localparam logic [1:0] SAS_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    SAS_ST_IDLE = 2'b01,
    SAS_ST_CONV = 2'b10
  } sas_sar_state_type;
endpackage : sas_pkg

/* File: core/sas_sar_core.sv */
`timescale 1ns/1ps
// successive-approximation engine, one trial bit per tick
module sas_sar_core
  import sas_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  sas_conv_if.eng conv
);
  sas_sar_state_type state_r;
  logic [2:0] idx_r;
  logic [SAS_RES_W-1:0] code_r;
  logic [SAS_RES_W-1:0] kept;
  logic [SAS_RES_W-1:0] bit_m;

  // drop the trial bit when the comparator says input is below it
  assign bit_m = 8'h01 << idx_r;
  assign kept = conv.cmp ? code_r : (code_r & ~bit_m);
  assign conv.busy = (state_r == SAS_ST_CONV);
  assign conv.dac_code = code_r;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_r <= SAS_ST_IDLE;
      idx_r <= 3'h7;
      code_r <= 8'h00;
      conv.done <= 1'b0;
      conv.result <= 8'h00;
    end
    else
    begin
      conv.done <= 1'b0;
      case (state_r)
        SAS_ST_IDLE:
        begin
          if (conv.start)
          begin
            state_r <= SAS_ST_CONV;
            idx_r <= 3'h7;
            code_r <= 8'h80;
          end
        end
        SAS_ST_CONV:
        begin
          if (conv.abort)
            state_r <= SAS_ST_IDLE;
          else if (conv.tick && idx_r == 3'h0)
          begin
            state_r <= SAS_ST_IDLE;
            conv.done <= 1'b1;
            conv.result <= kept;
            code_r <= kept;
          end
          else if (conv.tick)
          begin
            idx_r <= idx_r - 3'h1;
            code_r <= kept | (bit_m >> 1);
          end
        end
        default: state_r <= SAS_ST_IDLE;
      endcase
    end
  end
endmodule : sas_sar_core

/* File: core/sas_tad_gen.sv */
`timescale 1ns/1ps
// bit-period tick generator: oscillator divided, or the rc clock
module sas_tad_gen
  import sas_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic i_sleep,
  input wire logic i_rc_clk,
  input wire logic [1:0] i_sel,
  output logic o_tick
);
  logic [4:0] cnt_r;
  logic [4:0] lim;
  logic rc_prev_r;
  logic osc_tick;
  logic rc_tick;

  // divider limit per clock select code
  assign lim = (i_sel == SAS_CLK_DIV2) ? SAS_LIM_DIV2 :
               (i_sel == SAS_CLK_DIV8) ? SAS_LIM_DIV8 : SAS_LIM_DIV32;
  // oscillator ticks stop in sleep, the rc clock keeps running
  assign osc_tick = i_run && !i_sleep && (i_sel != SAS_CLK_RC)
                    && (cnt_r == lim);
  assign rc_tick = i_run && (i_sel == SAS_CLK_RC) && i_rc_clk
                   && !rc_prev_r;
  assign o_tick = osc_tick || rc_tick;

  // counter restarts when idle so every conversion starts aligned
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_r <= 5'h00;
      rc_prev_r <= 1'b0;
    end
    else
    begin
      rc_prev_r <= i_rc_clk;
      if (!i_run || osc_tick)
        cnt_r <= 5'h00;
      else if (!i_sleep)
        cnt_r <= cnt_r + 5'h01;
    end
  end
endmodule : sas_tad_gen

/* File: sim/sas_src_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// four analog sources behind the comparator
// ----------------------------------------------------------------
module sas_src_model
  import sas_pkg::*;
(
  input wire logic i_clk,
  input wire logic [1:0] i_channel,
  input wire logic i_hold,
  input wire logic i_power,
  input wire logic [sas_pkg::SAS_RES_W-1:0] i_dac_code,
  input wire logic [31:0] i_levels,
  output logic o_cmp
);
  logic flip_r = 1'b0;
  logic [7:0] level;
  // outside a conversion the comparator toggles, so no stale level helps
  always @(posedge i_clk)
    flip_r <= !flip_r;
  // sources only drive the pins; the block treats them as inputs
  assign level = i_levels[8*i_channel +: 8];
  assign o_cmp = (i_hold && i_power) ? (level >= i_dac_code) : flip_r;
endmodule : sas_src_model

/* File: sim/test_sar_adc_sequencer.sv */
`timescale 1ns/1ps
module test_sar_adc_sequencer;
  import sas_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [31:0] LVL = 32'hC300FF5A;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_awaddr = 8'h00;
  logic [7:0] i_araddr = 8'h00;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic i_arvalid = 1'b0, i_rready = 1'b0;
  logic [31:0] i_wdata = 32'h00000000;
  logic [3:0] i_wstrb = 4'hF;
  logic [3:0] i_port_pins = 4'hF;
  logic i_sleep = 1'b0, i_rc_clk = 1'b0, i_cmp;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp, o_channel, rsp;
  logic [31:0] o_rdata, rd;
  logic o_vref_pin, o_hold, o_power, o_wake;
  logic [7:0] o_dac_code;
  int mismatches = 0, n_tests = 0, hold_cnt = 0;
  int dv[4] = '{2, 8, 32, 7};
  always #5 i_clk = !i_clk;
  // rc clock of seven system clocks, changed just after an edge so
  // no sample of it races the clock
  int rc_cnt = 0;
  always @(posedge i_clk)
  begin
    rc_cnt <= (rc_cnt == 6) ? 0 : rc_cnt + 1;
    i_rc_clk <= (rc_cnt >= 3);
  end
  always @(posedge i_clk)
    if (o_hold) hold_cnt <= hold_cnt + 1;
  sas_adc_top sas_adc_top_inst (.i_clk(i_clk), .i_rst(i_rst),
    .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
    .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
    .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .i_sleep(i_sleep),
    .i_rc_clk(i_rc_clk), .i_cmp(i_cmp), .i_port_pins(i_port_pins),
    .o_channel(o_channel), .o_vref_pin(o_vref_pin), .o_hold(o_hold),
    .o_power(o_power), .o_dac_code(o_dac_code), .o_wake(o_wake));
  sas_src_model sas_src_model_inst (.i_clk(i_clk),
    .i_channel(o_channel), .i_hold(o_hold), .i_power(o_power),
    .i_dac_code(o_dac_code), .i_levels(LVL), .o_cmp(i_cmp));
  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] s, e, input string m);
    n_tests++;
    if (s !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %0t %s got %h want %h", $time, m, s, e);
    end
  endtask : chk
  task automatic hang(input string m);
    mismatches++;
    $display("CHECK FAILED %0t no answer: %s", $time, m);
    test_done();
  endtask : hang
  // each channel is released at the edge where its ready was seen high
  task automatic axw(input logic [7:0] idx, d, output logic [1:0] r);
    int k;
    logic a, w, b;
    @(posedge i_clk);
    i_awaddr <= idx << 2;
    i_wdata <= {24'h000000, d};
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    for (k = 0; k < 100; k++)
    begin
      @(negedge i_clk);
      a = o_awready && i_awvalid;
      w = o_wready && i_wvalid;
      b = o_bvalid;
      r = o_bresp;
      @(posedge i_clk);
      if (a) i_awvalid <= 1'b0;
      if (w) i_wvalid <= 1'b0;
      if (b) break;
    end
    i_bready <= 1'b0;
    if (k == 100) hang("write");
  endtask : axw
  task automatic axr(input logic [7:0] idx, output logic [31:0] d,
    output logic [1:0] r);
    int k;
    logic a, v;
    @(posedge i_clk);
    i_araddr <= idx << 2;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    for (k = 0; k < 100; k++)
    begin
      @(negedge i_clk);
      a = o_arready && i_arvalid;
      v = o_rvalid;
      d = o_rdata;
      r = o_rresp;
      @(posedge i_clk);
      if (a) i_arvalid <= 1'b0;
      if (v) break;
    end
    i_rready <= 1'b0;
    if (k == 100) hang("read");
  endtask : axr
  // configure and power first, acquire, then set go
  task automatic start(input logic [7:0] cfg);
    axw(SAS_IDX_CTRL, cfg, rsp);
    repeat (4) @(posedge i_clk);
    hold_cnt = 0;
    axw(SAS_IDX_CTRL, cfg | 8'h04, rsp);
  endtask : start
  task automatic wait_idle;
    int k;
    for (k = 0; k < 200; k++)
    begin
      axr(SAS_IDX_CTRL, rd, rsp);
      if (rd[SAS_CTRL_GO_BIT] === 1'b0) break;
    end
    if (k == 200) hang("conversion");
  endtask : wait_idle
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] ix[4] = '{SAS_IDX_CTRL, SAS_IDX_PINCFG, SAS_IDX_FLAGS,
      SAS_IDX_PORT};
    foreach (ix[i])
    begin
      axr(ix[i], rd, rsp);
      chk(rd, 32'h00000000, "reset value");
    end
    chk(32'(o_power), 32'h0, "power at reset");
    axw(8'h30, 8'hFF, rsp);
    chk(32'(rsp), 32'(SAS_RESP_SLVERR), "unmapped write");
    axr(8'h30, rd, rsp);
    chk(rd, 32'h00000000, "unmapped data");
    chk(32'(rsp), 32'(SAS_RESP_SLVERR), "unmapped read");
    $display("test reset done");
  endtask : t_reset
  // every clock code, each on its own channel, bounds and levels 5A and C3
  task automatic t_conv;
    logic [7:0] cfg;
    for (int c = 0; c < 4; c++)
    begin
      cfg = {c[1:0], 1'b0, c[1:0], 3'b001};
      axw(SAS_IDX_FLAGS, 8'h00, rsp);
      start(cfg);
      chk(32'(o_channel), 32'(c), "channel");
      wait_idle();
      chk(rd, 32'(cfg), "go cleared");
      chk(32'(hold_cnt >= 7 * dv[c] && hold_cnt <= 9 * dv[c]), 1,
        "period");
      axr(SAS_IDX_RESULT, rd, rsp);
      chk(rd, 32'(LVL[8*c +: 8]), "result");
      axr(SAS_IDX_FLAGS, rd, rsp);
      chk(rd, 32'h00000001, "done flag");
      repeat (2 * dv[c]) @(posedge i_clk);
    end
    $display("test conversions done");
  endtask : t_conv
  task automatic t_power;
    axw(SAS_IDX_CTRL, 8'h04, rsp);
    axr(SAS_IDX_CTRL, rd, rsp);
    chk(rd, 32'h00000000, "go without power");
    chk(32'(o_hold), 32'h0, "no hold");
    start(8'h89);
    repeat (20) @(posedge i_clk);
    chk(32'(o_power), 32'h1, "power on");
    axw(SAS_IDX_CTRL, 8'h00, rsp);
    repeat (2) @(posedge i_clk);
    chk(32'({o_power, o_hold}), 32'h0, "shut off");
    axr(SAS_IDX_RESULT, rd, rsp);
    chk(rd, 32'(LVL[31:24]), "result kept");
    start(8'h41);
    repeat (10) @(posedge i_clk);
    axw(SAS_IDX_CTRL, 8'h5D, rsp);
    chk(32'(o_channel), 32'h0, "channel held");
    wait_idle();
    axr(SAS_IDX_RESULT, rd, rsp);
    chk(rd, 32'(LVL[7:0]), "run undisturbed");
    $display("test power done");
  endtask : t_power
  task automatic t_sleep;
    axw(SAS_IDX_FLAGS, 8'h02, rsp);
    i_sleep <= 1'b1;
    start(8'hC1);
    wait_idle();
    repeat (2) @(posedge i_clk);
    chk(32'(o_wake), 32'h1, "rc wake");
    axw(SAS_IDX_FLAGS, 8'h02, rsp);
    start(8'h09);
    repeat (60) @(posedge i_clk);
    chk(32'({o_hold, o_wake}), 32'h2, "osc stalls");
    i_sleep <= 1'b0;
    wait_idle();
    repeat (2) @(posedge i_clk);
    chk(32'(o_wake), 32'h0, "no wake awake");
    axr(SAS_IDX_RESULT, rd, rsp);
    chk(rd, 32'(LVL[15:8]), "result after stall");
    $display("test sleep done");
  endtask : t_sleep
  task automatic t_pins;
    i_port_pins <= 4'hE;
    axw(SAS_IDX_FLAGS, 8'h00, rsp);
    axw(SAS_IDX_PINCFG, 8'h1F, rsp);
    chk(32'(rsp), 32'(SAS_RESP_OKAY), "mapped write");
    chk(32'(o_vref_pin), 32'h1, "pin reference");
    axr(SAS_IDX_PORT, rd, rsp);
    chk(rd, 32'h0000000E, "digital view");
    axr(SAS_IDX_FLAGS, rd, rsp);
    chk(rd, 32'h00000018, "port change and external");
    axw(SAS_IDX_PINCFG, 8'h00, rsp);
    chk(32'(o_vref_pin), 32'h0, "supply reference");
    $display("test pins done");
  endtask : t_pins
  initial
  begin
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset();
    t_conv();
    t_power();
    t_sleep();
    t_pins();
    test_done();
  end
endmodule : test_sar_adc_sequencer
